//--- hdl/mofe_pkg.sv
// Constants, field layouts and carriers for the offload and function event register bank.
// Assumes a 32-bit classic Wishbone slave port with byte selects.
package mofe_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int WB_ADR_W = 10;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int IDX_LSB  = 2;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_RX_MAX_LEN = 8'hDA;
  localparam logic [7:0] IDX_CMD        = 8'hE0;
  localparam logic [7:0] IDX_RING_LO    = 8'hE4;
  localparam logic [7:0] IDX_RING_HI    = 8'hE8;
  localparam logic [7:0] IDX_ETX        = 8'hEC;
  localparam logic [7:0] IDX_FEVT       = 8'hF0;
  localparam logic [7:0] IDX_FFORCE     = 8'hFC;
  localparam logic [7:0] IDX_CFG3       = 8'hD4;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int RX_LEN_W       = 14;
  localparam int CMD_ENDIAN_BIT = 9;
  localparam int CMD_TAG_BIT    = 6;
  localparam int CMD_CSUM_BIT   = 5;
  localparam int CMD_DAC_BIT    = 4;
  localparam int CMD_MRW_BIT    = 3;
  localparam int ETX_W          = 6;
  localparam int ETX_UNIT_SHIFT = 5;
  localparam int EVT_A_BIT      = 15;
  localparam int GENERAL_WAKE_BIT      = 4;
  localparam int CFG3_CARD_BIT  = 3;
  localparam int CFG3_FREG_BIT  = 1;
  localparam logic [1:0] CMD_WORD_SEL = 2'h3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [RX_LEN_W-1:0] RST_RX_MAX_LEN = 14'h0000;
  localparam logic [ETX_W-1:0]    RST_ETX        = 6'h01;
  localparam logic [31:0]         RST_RING       = 32'h0000_0000;

  typedef struct packed {
    logic big_endian;
    logic rx_tag_strip_en;
    logic rx_csum_offload_en;
    logic dac_en;
    logic multi_rw_en;
  } mofe_cmd_s;

  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_DAT_W-1:0] dat;
  } mofe_wb_req_s;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] mofe_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

//--- hdl/mofe_event_bit.sv
// Sticky event flag with power-on reset only.
// Assumes set, clear and soft clear are synchronous one-cycle pulses.
`timescale 1ns/1ns
module mofe_event_bit (
  // Clock and power-on reset
  input  wire logic i_clk,
  input  wire logic i_npor,
  // Events
  input  wire logic i_set,
  input  wire logic i_clr,
  input  wire logic i_soft_clr,
  // Flag
  output logic      o_flag
);

  // ---------------------------------------------------------------
  // Flag
  // ---------------------------------------------------------------
  // Set beats clear
  always_ff @(posedge i_clk or negedge i_npor) begin
    if (!i_npor) begin
      o_flag <= 1'h0;
    end else if (i_set) begin
      o_flag <= 1'h1;
    end else if (i_clr || i_soft_clr) begin
      o_flag <= 1'h0;
    end
  end

  a_set_wins_clr: assert property (@(posedge i_clk) disable iff (!i_npor)
    i_set |=> o_flag) else $error("event flag lost a set");

endmodule

//--- hdl/mofe_tx_start.sv
// Early transmit start decision from FIFO fill level.
// Assumes the FIFO byte count and whole-packet flag are synchronous to i_clk.
`timescale 1ns/1ns
module mofe_tx_start
  import mofe_pkg::*;
#(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Threshold and FIFO state
  input  wire logic [ETX_W-1:0] i_level,
  input  wire logic [CNT_W-1:0] i_fifo_bytes,
  input  wire logic             i_fifo_has_pkt,
  // Start request
  output logic                  o_start
);

  if (CNT_W < ETX_W + ETX_UNIT_SHIFT) begin : g_chk
    $error("CNT_W too narrow for the threshold");
  end

  logic [CNT_W-1:0] thr_bytes;

  assign thr_bytes = CNT_W'(i_level) << ETX_UNIT_SHIFT;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_start <= 1'h0;
    end else begin
      o_start <= (i_fifo_bytes >= thr_bytes) || i_fifo_has_pkt;
    end
  end

  a_tx_start_level: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_fifo_bytes >= (CNT_W'(i_level) * CNT_W'(32))) |=> o_start)
    else $error("threshold reached without start");

  a_tx_start_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_start |-> $past(i_fifo_has_pkt || (i_fifo_bytes >= thr_bytes)))
    else $error("start without cause");

endmodule

//--- hdl/mofe_regs.sv
// Offload command, receive length, ring base, early transmit and function event registers.
// Assumes a classic Wishbone master on i_clk and a separate power-on reset for event flags.
//
// Function
// - Receive length spans full 14-bit range
// - Command bit 6 enables tag removal
// - Command bit 5 enables receive checksum
// - Dual address only for nonzero upper address
// - Multi read/write ignores burst size limit
// - Command word changes only on writes selecting both low byte lanes
// - Ring base halves at E4h and E8h
// - Transmit starts at threshold or whole packet
// - Threshold counts in 32-byte units
// - Forced interrupt field sets event bit 15
// - Wake rise or force sets bit 4
// - Write one clears event, zero keeps
// - Event bits survive resets as specified
// - Event register needs both enable bits
// - Status change pin reports events, high
`timescale 1ns/1ns
module mofe_regs
  import mofe_pkg::*;
#(
  parameter int FIFO_CNT_W = 12
) (
  // Clock and resets
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_npor,
  input  wire logic                  i_soft_rst,
  // Wishbone slave
  input  wire mofe_pkg::mofe_wb_req_s i_wb,
  output logic                       o_wb_ack,
  output logic [mofe_pkg::WB_DAT_W-1:0] o_wb_dat,
  // Receive configuration
  output logic [mofe_pkg::RX_LEN_W-1:0] o_rx_max_len,
  output logic                       o_rx_accept_en,
  output mofe_pkg::mofe_cmd_s        o_cmd,
  output logic [63:0]                o_rx_desc_base,
  // DMA steering
  input  wire logic [31:0]           i_buf_addr_hi,
  output logic                       o_use_dac,
  output logic                       o_burst_limit_en,
  // Transmit FIFO
  input  wire logic [FIFO_CNT_W-1:0] i_tx_fifo_bytes,
  input  wire logic                  i_tx_fifo_has_pkt,
  output logic                       o_tx_start,
  // Function events
  input  wire logic                  i_present_wake,
  output logic                       o_status_change_pin
);

  if (FIFO_CNT_W < 11) begin : g_chk
    $error("FIFO_CNT_W must hold 2K byte counts");
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [RX_LEN_W-1:0] rx_max_len;
  mofe_cmd_s           cmd;
  logic [31:0]         ring_lo;
  logic [31:0]         ring_hi;
  logic [ETX_W-1:0]    early_tx_level;
  logic                card_en;
  logic                func_regs_en;
  logic                wake_q;
  logic                event_a;
  logic                general_wake;
  logic                ack;
  logic [31:0]         next_rdat;
  logic [31:0]         wmerge;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic       fevt_on;
  logic       cmd_word_wr;
  logic       set_a;
  logic       set_g;
  logic       clr_a;
  logic       clr_g;

  assign req     = i_wb.cyc && i_wb.stb && !ack;
  assign wr      = i_wb.cyc && i_wb.stb && i_wb.we && ack;
  assign idx     = i_wb.adr[IDX_LSB +: 8];
  assign wmerge  = i_wb.dat;
  assign fevt_on = card_en && func_regs_en;
  // Only a full 16-bit lane pair
  assign cmd_word_wr = wr && (idx == IDX_CMD) && (i_wb.sel[1:0] == CMD_WORD_SEL);
  assign set_a = wr && fevt_on && (idx == IDX_FFORCE) && i_wb.sel[EVT_A_BIT/8]
                 && i_wb.dat[EVT_A_BIT];
  assign set_g = (i_present_wake && !wake_q)
                 || (wr && fevt_on && (idx == IDX_FFORCE) && i_wb.sel[GENERAL_WAKE_BIT/8]
                     && i_wb.dat[GENERAL_WAKE_BIT]);
  assign clr_a = wr && fevt_on && (idx == IDX_FEVT) && i_wb.sel[EVT_A_BIT/8]
                 && i_wb.dat[EVT_A_BIT];
  assign clr_g = wr && fevt_on && (idx == IDX_FEVT) && i_wb.sel[GENERAL_WAKE_BIT/8]
                 && i_wb.dat[GENERAL_WAKE_BIT];

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  // Every access, mapped or not, is answered one cycle later; writes land on the ack edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack <= 1'h0;
    end else begin
      ack <= req;
    end
  end

  always_comb begin
    next_rdat = '0;
    case (idx)
      IDX_RX_MAX_LEN: begin
        next_rdat = 32'(rx_max_len);
      end
      IDX_CMD: begin
        next_rdat[CMD_ENDIAN_BIT] = cmd.big_endian;
        next_rdat[CMD_TAG_BIT]    = cmd.rx_tag_strip_en;
        next_rdat[CMD_CSUM_BIT]   = cmd.rx_csum_offload_en;
        next_rdat[CMD_DAC_BIT]    = cmd.dac_en;
        next_rdat[CMD_MRW_BIT]    = cmd.multi_rw_en;
      end
      IDX_RING_LO: begin
        next_rdat = ring_lo;
      end
      IDX_RING_HI: begin
        next_rdat = ring_hi;
      end
      IDX_ETX: begin
        next_rdat = 32'(early_tx_level);
      end
      IDX_FEVT: begin
        // Reads as zero while the function registers are disabled
        next_rdat[EVT_A_BIT] = fevt_on && event_a;
        next_rdat[GENERAL_WAKE_BIT] = fevt_on && general_wake;
      end
      IDX_CFG3: begin
        next_rdat[CFG3_CARD_BIT] = card_en;
        next_rdat[CFG3_FREG_BIT] = func_regs_en;
      end
      default: begin
        next_rdat = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_dat <= '0;
    end else if (req && !i_wb.we) begin
      o_wb_dat <= next_rdat;
    end
  end
  assign o_wb_ack = ack;

  // ---------------------------------------------------------------
  // Receive length
  // ---------------------------------------------------------------
  // All 14 bits stored
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_max_len <= RST_RX_MAX_LEN;
    end else if (wr && (idx == IDX_RX_MAX_LEN)) begin
      rx_max_len <= RX_LEN_W'(mofe_merge(32'(rx_max_len), wmerge, i_wb.sel));
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_accept_en <= 1'h0;
    end else begin
      o_rx_accept_en <= (rx_max_len != RST_RX_MAX_LEN);
    end
  end
  assign o_rx_max_len = rx_max_len;

  // ---------------------------------------------------------------
  // Offload command word
  // ---------------------------------------------------------------
  // Command fields
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd <= '0;
    end else if (cmd_word_wr) begin
      cmd.big_endian         <= i_wb.dat[CMD_ENDIAN_BIT];
      cmd.rx_tag_strip_en    <= i_wb.dat[CMD_TAG_BIT];
      cmd.rx_csum_offload_en <= i_wb.dat[CMD_CSUM_BIT];
      cmd.dac_en             <= i_wb.dat[CMD_DAC_BIT];
      cmd.multi_rw_en        <= i_wb.dat[CMD_MRW_BIT];
    end
  end
  assign o_cmd = cmd;

  // Dual address for high buffers only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_use_dac <= 1'h0;
    end else begin
      o_use_dac <= cmd.dac_en && (i_buf_addr_hi != 32'h0000_0000);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_burst_limit_en <= 1'h1;
    end else begin
      o_burst_limit_en <= !cmd.multi_rw_en;
    end
  end

  // ---------------------------------------------------------------
  // Receive descriptor ring base
  // ---------------------------------------------------------------
  // Low and high halves
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ring_lo <= RST_RING;
      ring_hi <= RST_RING;
    end else if (wr && (idx == IDX_RING_LO)) begin
      ring_lo <= mofe_merge(ring_lo, wmerge, i_wb.sel);
    end else if (wr && (idx == IDX_RING_HI)) begin
      ring_hi <= mofe_merge(ring_hi, wmerge, i_wb.sel);
    end
  end
  // Alignment is left to software; low bits are kept as written
  assign o_rx_desc_base = {ring_hi, ring_lo};

  // ---------------------------------------------------------------
  // Early transmit threshold
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      early_tx_level <= RST_ETX;
    end else if (wr && (idx == IDX_ETX)) begin
      early_tx_level <= ETX_W'(mofe_merge(32'(early_tx_level), wmerge, i_wb.sel));
    end
  end
  // Code zero starts at once; it is reserved, so nothing better is owed
  mofe_tx_start #(
    .CNT_W(FIFO_CNT_W)
  ) u_tx_start (
    .i_clk         (i_clk),
    .i_nrst        (i_nrst),
    .i_level       (early_tx_level),
    .i_fifo_bytes  (i_tx_fifo_bytes),
    .i_fifo_has_pkt(i_tx_fifo_has_pkt),
    .o_start       (o_tx_start)
  );

  // ---------------------------------------------------------------
  // Function enables
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      card_en      <= 1'h0;
      func_regs_en <= 1'h0;
    end else if (wr && (idx == IDX_CFG3) && i_wb.sel[0]) begin
      card_en      <= i_wb.dat[CFG3_CARD_BIT];
      func_regs_en <= i_wb.dat[CFG3_FREG_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Function events
  // ---------------------------------------------------------------
  // Edge detector on power-on reset so a bus reset cannot fake a rise
  always_ff @(posedge i_clk or negedge i_npor) begin
    if (!i_npor) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= i_present_wake;
    end
  end

  mofe_event_bit u_event_a (
    .i_clk     (i_clk),
    .i_npor    (i_npor),
    .i_set     (set_a),
    .i_clr     (clr_a),
    .i_soft_clr(1'h0),
    .o_flag    (event_a)
  );

  // Wake bit ignores the reset pin only
  mofe_event_bit u_general_wake (
    .i_clk     (i_clk),
    .i_npor    (i_npor),
    .i_set     (set_g),
    .i_clr     (clr_g),
    .i_soft_clr(i_soft_rst),
    .o_flag    (general_wake)
  );

  always_ff @(posedge i_clk or negedge i_npor) begin
    if (!i_npor) begin
      o_status_change_pin <= 1'h0;
    end else begin
      o_status_change_pin <= fevt_on && (event_a || general_wake);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_cmd_byte_ignored: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr && (idx == IDX_CMD) && (i_wb.sel[1:0] != CMD_WORD_SEL)) |=> $stable(cmd))
    else $error("byte write changed command word");
  a_tag_strip_wr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd_word_wr |=> (o_cmd.rx_tag_strip_en == $past(i_wb.dat[CMD_TAG_BIT])))
    else $error("tag strip enable not taken");
  a_csum_en_wr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd_word_wr |=> (o_cmd.rx_csum_offload_en == $past(i_wb.dat[CMD_CSUM_BIT])))
    else $error("checksum enable not taken");
  a_endian_wr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd_word_wr |=> (o_cmd.big_endian == $past(i_wb.dat[CMD_ENDIAN_BIT])))
    else $error("endian select not taken");
  a_dac_high_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_use_dac |-> ($past(i_buf_addr_hi) != 32'h0000_0000) && $past(cmd.dac_en))
    else $error("dual address for low buffer");
  a_burst_cap_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd.multi_rw_en [*2] |-> !o_burst_limit_en)
    else $error("burst cap kept under multi read/write");
  a_len_full_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr && (idx == IDX_RX_MAX_LEN) && (i_wb.sel[1:0] == CMD_WORD_SEL))
    |=> (o_rx_max_len == $past(i_wb.dat[RX_LEN_W-1:0])))
    else $error("receive length truncated");
  a_ring_lo_map: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (wr && (idx == IDX_RING_LO) && (i_wb.sel == 4'hF))
    |=> (o_rx_desc_base[31:0] == $past(i_wb.dat)) && $stable(o_rx_desc_base[63:32]))
    else $error("ring base low half misplaced");
  a_force_sets_a: assert property (@(posedge i_clk) disable iff (!i_nrst || !i_npor)
    set_a |=> event_a ##1 (o_status_change_pin || !fevt_on))
    else $error("forced interrupt not latched");
  a_wake_rise: assert property (@(posedge i_clk) disable iff (!i_nrst || !i_npor)
    (i_present_wake && !wake_q) |=> general_wake)
    else $error("wake rise missed");
  a_w1c_clear: assert property (@(posedge i_clk) disable iff (!i_nrst || !i_npor)
    (clr_a && !set_a) |=> !event_a)
    else $error("write one did not clear");
  a_soft_keeps_a: assert property (@(posedge i_clk) disable iff (!i_npor)
    (event_a && !clr_a) |=> event_a)
    else $error("interrupt bit lost without clear");
  a_pin_gated: assert property (@(posedge i_clk) disable iff (!i_npor)
    o_status_change_pin |-> $past(fevt_on))
    else $error("pin raised while disabled");
  a_pin_follows: assert property (@(posedge i_clk) disable iff (!i_npor)
    (fevt_on && (event_a || general_wake)) |=> o_status_change_pin)
    else $error("pin missed pending event");

endmodule

//--- bench/mofe_host.sv
// Bus master model standing in for host software on the register bus.
// Assumes a classic Wishbone slave that acks every request; the bench watchdog ends a hang.
`timescale 1ns/1ns
module mofe_host
  import mofe_pkg::*;
(
  // Bus
  input  wire logic                 i_clk,
  input  wire logic                 i_ack,
  input  wire logic [WB_DAT_W-1:0]  i_dat,
  output mofe_pkg::mofe_wb_req_s    o_wb
);
  initial o_wb = '0;

  // Request held until ack is sampled high, then released for a cycle
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rv);
    @(posedge i_clk);
    o_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: sel, dat: wd};
    @(posedge i_clk);
    while (i_ack !== 1'b1) @(posedge i_clk);
    rv = i_dat;
    o_wb.cyc <= 1'b0;
    o_wb.stb <= 1'b0;
    // Released data and we lines do not keep the old value, so stale data cannot pass for new
    o_wb.dat <= ~wd;
    o_wb.we  <= ~we;
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the offload and function event register bank.
// Assumes mofe_host speaks the bus; the design acks one cycle after it takes a request.
`timescale 1ns/1ns
module tb_top;
  import mofe_pkg::*;
  logic         i_clk, i_nrst, i_npor, i_soft_rst, ack, pin, acc, dac, blim, start;
  logic         has_pkt, wake;
  mofe_wb_req_s wb;
  logic [31:0]  rdat, buf_hi, d;
  logic [13:0]  mlen;
  mofe_cmd_s    cmd;
  logic [63:0]  base;
  logic [11:0]  fbytes;
  int           failures, num_checks;
  int           pos [5] = '{9, 6, 5, 4, 3};

  mofe_host u_host (.i_clk(i_clk), .i_ack(ack), .i_dat(rdat), .o_wb(wb));
  mofe_regs #(.FIFO_CNT_W(12)) u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_npor(i_npor), .i_soft_rst(i_soft_rst),
    .i_wb(wb), .o_wb_ack(ack), .o_wb_dat(rdat), .o_rx_max_len(mlen),
    .o_rx_accept_en(acc), .o_cmd(cmd), .o_rx_desc_base(base), .i_buf_addr_hi(buf_hi),
    .o_use_dac(dac), .o_burst_limit_en(blim), .i_tx_fifo_bytes(fbytes),
    .i_tx_fifo_has_pkt(has_pkt), .o_tx_start(start), .i_present_wake(wake),
    .o_status_change_pin(pin));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [3:0] sel, input logic [31:0] v);
    u_host.xfer(1'b1, idx, sel, v, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    u_host.xfer(1'b0, idx, 4'hF, 32'h0000_0000, d);
    chk(d, exp);
  endtask
  // Registered outputs lag their cause by one cycle; two edges leave margin
  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {i_nrst, i_npor, i_soft_rst, has_pkt, wake} = 5'h00;
    buf_hi = 32'h0000_0000;
    fbytes = 12'h000;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    i_npor <= 1'b1;
    settle();
    chk(blim, 1'b1);
    chk(acc, 1'b0);
    rdc(IDX_ETX, 32'h0000_0001);
    // Command word first, as software does: bit map and word-only writes
    for (int i = 0; i < 5; i++) begin
      wr(IDX_CMD, 4'h3, 32'h1 << pos[i]);
      settle();
      chk(cmd, 5'h10 >> i);
    end
    chk(blim, 1'b0);
    wr(IDX_CMD, 4'h1, 32'h0000_0010);
    wr(IDX_CMD, 4'h2, 32'h0000_0010);
    rdc(IDX_CMD, 32'h0000_0008);
    wr(IDX_CMD, 4'h3, 32'h0000_0278);
    rdc(IDX_CMD, 32'h0000_0278);
    settle();
    chk(dac, 1'b0);
    @(posedge i_clk);
    buf_hi <= 32'h0000_0001;
    settle();
    chk(dac, 1'b1);
    wr(IDX_RX_MAX_LEN, 4'h3, 32'h0000_3FFF);
    rdc(IDX_RX_MAX_LEN, 32'h0000_3FFF);
    settle();
    chk({acc, mlen}, {1'b1, 14'h3FFF});
    // Ring base kept on a 256-byte boundary
    wr(IDX_RING_LO, 4'hF, 32'hABCD_EF00);
    wr(IDX_RING_HI, 4'hF, 32'h1234_5678);
    settle();
    chk(base, 64'h1234_5678_ABCD_EF00);
    rdc(IDX_RING_HI, 32'h1234_5678);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h10, 32'h0000_0000);
    // Level 2 is 64 bytes: nonzero and below 2K
    wr(IDX_ETX, 4'h1, 32'h0000_0002);
    fbytes <= 12'h03F;
    settle();
    chk(start, 1'b0);
    @(posedge i_clk);
    fbytes <= 12'h040;
    settle();
    chk(start, 1'b1);
    @(posedge i_clk);
    fbytes <= 12'h000;
    has_pkt <= 1'b1;
    settle();
    chk(start, 1'b1);
    // Function events, first with the enables off
    wr(IDX_FFORCE, 4'hF, 32'h0000_8000);
    rdc(IDX_FEVT, 32'h0000_0000);
    // One enable alone must not open the event registers
    wr(IDX_CFG3, 4'h1, 32'h0000_0008);
    wr(IDX_FFORCE, 4'hF, 32'h0000_8000);
    rdc(IDX_FEVT, 32'h0000_0000);
    wr(IDX_CFG3, 4'h1, 32'h0000_000A);
    rdc(IDX_CFG3, 32'h0000_000A);
    rdc(IDX_FEVT, 32'h0000_0000);
    wr(IDX_FFORCE, 4'hF, 32'h0000_8000);
    rdc(IDX_FEVT, 32'h0000_8000);
    settle();
    chk(pin, 1'b1);
    @(posedge i_clk);
    wake <= 1'b1;
    settle();
    rdc(IDX_FEVT, 32'h0000_8010);
    i_nrst <= 1'b0;
    settle();
    @(posedge i_clk);
    i_nrst <= 1'b1;
    wr(IDX_CFG3, 4'h1, 32'h0000_000A);
    rdc(IDX_FEVT, 32'h0000_8010);
    i_soft_rst <= 1'b1;
    @(posedge i_clk);
    i_soft_rst <= 1'b0;
    rdc(IDX_FEVT, 32'h0000_8000);
    wr(IDX_FEVT, 4'hF, 32'h0000_0000);
    rdc(IDX_FEVT, 32'h0000_8000);
    wr(IDX_FEVT, 4'hF, 32'h0000_8000);
    rdc(IDX_FEVT, 32'h0000_0000);
    settle();
    chk(pin, 1'b0);
    wr(IDX_FFORCE, 4'hF, 32'h0000_0010);
    rdc(IDX_FEVT, 32'h0000_0010);
    final_report();
  end

  // Tests take well under a thousand cycles
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
